// file: src/dpbo_phase_buildout.sv
// Purpose: reference switching with phase build-out and phase trims
// Assumes: phase_meas_in LSB equals one trim step, 0.101 ns
// Notes: the loop filter itself lies outside; this block steers it
`timescale 1ns/1ps
`default_nettype none
`include "dpbo_params.svh"

module dpbo_phase_buildout #(
    parameter int NREF = 4,
    parameter int PH_W = 16,
    parameter int MEAS_LOG2 = 4,
    parameter int LEAK_CYC = `DPBO_CYC_MIN(`DPBO_LEAK_NS),
    parameter int BAD_CYC = `DPBO_CYC_MIN(`DPBO_BAD_NS),
    parameter int GOOD_CYC = `DPBO_CYC_MIN(`DPBO_GOOD_NS),
    parameter int LOL_CYC = `DPBO_CYC_MIN(`DPBO_LOL_NS),
    parameter int REL_CYC = `DPBO_CYC_MIN(`DPBO_REL_NS)
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic [NREF-1:0] ref_clk_in,
    input wire logic [NREF-1:0] ref_freq_ok_in,
    input wire logic [NREF-1:0] ref_purity_ok_in,
    input wire logic lock_in,
    input wire logic [PH_W-1:0] phase_meas_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic [1:0] sel_ref_out,
    output logic sel_valid_out,
    output logic holdover_out,
    output logic buildout_event_out,
    output logic [PH_W-1:0] buildout_offset_out,
    output logic [15:0] phase_adjust_out,
    output logic [3:0] bandwidth_sel_out,
    output logic [NREF-1:0] unserviceable_out
);

    localparam int GAP_CYC = `DPBO_CYC_MIN(`DPBO_GAP_NS);
    localparam int LONG_CYC = `DPBO_CYC_MIN(`DPBO_LONG_NS);
    localparam int HOLD_CYC = `DPBO_CYC_MIN(`DPBO_HOLD_NS);
    localparam int ACC_W = PH_W + MEAS_LOG2;

    typedef struct packed {
        dpbo_pkg::dpbo_state_e st;
        logic pbo_en;
        logic auto_pbo;
        logic freeze;
        logic [3:0] bw_lock;
        logic [3:0] bw_acq;
        logic [7:0] adj_lo;
        logic [7:0] adj_hi;
        logic [7:0] trim;
        logic [1:0] sel;
        logic sel_valid;
        logic evt;
        logic [PH_W-1:0] offset;
        logic [ACC_W-1:0] acc;
        logic [MEAS_LOG2:0] nsamp;
        logic [15:0] cnt;
        logic [15:0] lol_cnt;
        logic [NREF-1:0] block;
        logic [15:0] rel_cnt;
        logic [7:0] rdata;
        logic [15:0] adj_out;
        logic [3:0] bw_out;
    } dpbo_top_s;

    dpbo_top_s q_r;
    dpbo_top_s q_nxt;
    logic [NREF-1:0] mon_ok;
    logic [NREF-1:0] cand;
    logic [1:0] pick;
    logic pick_valid;
    logic cur_ok;
    logic freeze_eff;
    logic trigger;
    logic [7:0] trim_c;
    logic [3:0] bw_l;
    logic [3:0] bw_a;

    // one monitor per reference port
    for (genvar i = 0; i < NREF; i++) begin : g_mon
        dpbo_ref_monitor #(
            .GAP_CYC(GAP_CYC),
            .LONG_CYC(LONG_CYC),
            .LEAK_CYC(LEAK_CYC),
            .BAD_CYC(BAD_CYC),
            .GOOD_CYC(GOOD_CYC)
        ) u_mon (
            .clock_in(clock_in),
            .rstn_in(rstn_in),
            .ref_pin_in(ref_clk_in[i]),
            .quality_ok_in(ref_freq_ok_in[i] & ref_purity_ok_in[i]),
            .ok_out(mon_ok[i])
        );
    end

    always_comb begin
        q_nxt = q_r;
        q_nxt.evt = 1'b0;
        trigger = 1'b0;

        // register writes
        if (reg_wr_in) begin
            case (reg_addr_in)
                `DPBO_ADDR_PBO_CTRL: q_nxt.pbo_en = reg_wdata_in[`DPBO_PBO_EN_BIT];
                `DPBO_ADDR_AUTO_CTRL: q_nxt.auto_pbo = reg_wdata_in[`DPBO_AUTO_BIT];
                `DPBO_ADDR_FREEZE: q_nxt.freeze = reg_wdata_in[`DPBO_FREEZE_BIT];
                `DPBO_ADDR_BW: begin
                    q_nxt.bw_lock = reg_wdata_in[3:0];
                    q_nxt.bw_acq = reg_wdata_in[7:4];
                end
                `DPBO_ADDR_PHADJ_LO: q_nxt.adj_lo = reg_wdata_in;
                `DPBO_ADDR_PHADJ_HI: q_nxt.adj_hi = reg_wdata_in;
                `DPBO_ADDR_TRIM: q_nxt.trim = reg_wdata_in;
                default: q_nxt.rdata = q_r.rdata;
            endcase
        end

        // freeze only counts while build-out is enabled
        freeze_eff = q_nxt.freeze & q_nxt.pbo_en;

        // priority: lowest index wins among serviceable references
        cand = mon_ok & ~q_r.block;
        pick = 2'h0;
        pick_valid = 1'b0;
        for (int i = NREF - 1; i >= 0; i--) begin
            if (cand[i]) begin
                pick = 2'(i);
                pick_valid = 1'b1;
            end
        end
        cur_ok = q_r.sel_valid && cand[q_r.sel];

        // persistent loss of lock rejects the selected source
        if (q_r.st == dpbo_pkg::ST_LOCKED && q_r.sel_valid && !lock_in) begin
            if (q_r.lol_cnt >= 16'(LOL_CYC - 1)) begin
                q_nxt.block[q_r.sel] = 1'b1;
                q_nxt.lol_cnt = 16'h0000;
            end else begin
                q_nxt.lol_cnt = q_r.lol_cnt + 16'h0001;
            end
        end else begin
            q_nxt.lol_cnt = 16'h0000;
        end
        // blocked sources get a retry after a long quiet spell
        if (|q_r.block) begin
            if (q_r.rel_cnt >= 16'(REL_CYC - 1)) begin
                // a block raised in this same cycle survives the release
                q_nxt.block = q_nxt.block & ~q_r.block;
                q_nxt.rel_cnt = 16'h0000;
            end else begin
                q_nxt.rel_cnt = q_r.rel_cnt + 16'h0001;
            end
        end

        // reselection on loss of the selected reference
        if (!cur_ok) begin
            q_nxt.sel_valid = pick_valid;
            if (pick_valid) begin
                q_nxt.sel = pick;
                if (q_r.sel_valid && q_nxt.pbo_en && !freeze_eff) begin
                    trigger = 1'b1;
                end
            end
        end

        // turning build-out on while locked measures afresh
        if (q_nxt.pbo_en && !q_r.pbo_en && lock_in && q_r.st == dpbo_pkg::ST_LOCKED && q_nxt.sel_valid) begin
            trigger = 1'b1;
        end

        case (q_r.st)
            dpbo_pkg::ST_LOCKED: begin
                q_nxt.cnt = 16'h0000;
            end
            dpbo_pkg::ST_HOLD: begin
                // output free-runs while the new reference settles
                if (q_r.cnt >= 16'(HOLD_CYC - 1)) begin
                    q_nxt.st = dpbo_pkg::ST_MEAS;
                    q_nxt.acc = '0;
                    q_nxt.nsamp = '0;
                end else begin
                    q_nxt.cnt = q_r.cnt + 16'h0001;
                end
            end
            dpbo_pkg::ST_MEAS: begin
                // averaging 2^k samples keeps detector noise out of the offset
                q_nxt.acc = q_r.acc + {{MEAS_LOG2{phase_meas_in[PH_W-1]}}, phase_meas_in};
                q_nxt.nsamp = q_r.nsamp + 1'b1;
                if (q_r.nsamp == (MEAS_LOG2 + 1)'((1 << MEAS_LOG2) - 1)) begin
                    q_nxt.st = dpbo_pkg::ST_INSERT;
                end
            end
            dpbo_pkg::ST_INSERT: begin
                q_nxt.offset = q_r.acc[ACC_W-1:MEAS_LOG2] + {{(PH_W - 8){trim_c[7]}}, trim_c};
                q_nxt.st = dpbo_pkg::ST_LOCKED;
            end
            default: begin
                q_nxt.st = dpbo_pkg::ST_LOCKED;
            end
        endcase

        if (trigger) begin
            q_nxt.evt = 1'b1;
            q_nxt.st = dpbo_pkg::ST_HOLD;
            q_nxt.cnt = 16'h0000;
        end

        // disabled: drop the offset, the loop then slews back at its bandwidth
        if (!q_nxt.pbo_en) begin
            q_nxt.offset = '0;
            q_nxt.st = dpbo_pkg::ST_LOCKED;
        end

        // feedback phase shift applies only with build-out fully off
        if (!q_nxt.pbo_en && !q_nxt.auto_pbo) begin
            q_nxt.adj_out = {q_nxt.adj_hi, q_nxt.adj_lo};
        end else begin
            q_nxt.adj_out = 16'h0000;
        end

        // lock indication chooses the bandwidth set
        q_nxt.bw_out = lock_in ? bw_l : bw_a;

        if (reg_rd_in) begin
            case (reg_addr_in)
                `DPBO_ADDR_PBO_CTRL: q_nxt.rdata = 8'(q_r.pbo_en) << `DPBO_PBO_EN_BIT;
                `DPBO_ADDR_AUTO_CTRL: q_nxt.rdata = 8'(q_r.auto_pbo) << `DPBO_AUTO_BIT;
                `DPBO_ADDR_FREEZE: q_nxt.rdata = 8'(q_r.freeze) << `DPBO_FREEZE_BIT;
                `DPBO_ADDR_BW: q_nxt.rdata = {q_r.bw_acq, q_r.bw_lock};
                `DPBO_ADDR_PHADJ_LO: q_nxt.rdata = q_r.adj_lo;
                `DPBO_ADDR_PHADJ_HI: q_nxt.rdata = q_r.adj_hi;
                `DPBO_ADDR_TRIM: q_nxt.rdata = q_r.trim;
                `DPBO_ADDR_STATUS: q_nxt.rdata = {q_r.st, q_r.sel_valid, q_r.sel, lock_in};
                `DPBO_ADDR_UNSERV: q_nxt.rdata = 8'(unserviceable_out);
                default: q_nxt.rdata = 8'h00;
            endcase
        end
    end

    // trim limited to the documented window, in whole steps
    always_comb begin
        if ($signed(q_r.trim) > `DPBO_TRIM_LIMIT) begin
            trim_c = 8'(`DPBO_TRIM_LIMIT);
        end else if ($signed(q_r.trim) < -`DPBO_TRIM_LIMIT) begin
            trim_c = 8'(-`DPBO_TRIM_LIMIT);
        end else begin
            trim_c = q_r.trim;
        end
    end

    // codes above the last setting fall back to the narrowest-to-widest top
    always_comb begin
        bw_l = (q_r.bw_lock > `DPBO_BW_MAX) ? `DPBO_BW_MAX : q_r.bw_lock;
        bw_a = (q_r.bw_acq > `DPBO_BW_MAX) ? `DPBO_BW_MAX : q_r.bw_acq;
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            q_r <= '0;
            q_r.st <= dpbo_pkg::ST_LOCKED;
            q_r.pbo_en <= `DPBO_RST_PBO_EN;
            q_r.bw_lock <= `DPBO_RST_BW_LOCK;
            q_r.bw_acq <= `DPBO_RST_BW_ACQ;
            q_r.bw_out <= `DPBO_RST_BW_ACQ;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign reg_rdata_out = q_r.rdata;
    assign sel_ref_out = q_r.sel;
    assign sel_valid_out = q_r.sel_valid;
    assign holdover_out = (q_r.st != dpbo_pkg::ST_LOCKED) | ~q_r.sel_valid;
    assign buildout_event_out = q_r.evt;
    assign buildout_offset_out = q_r.offset;
    assign phase_adjust_out = q_r.adj_out;
    assign bandwidth_sel_out = q_r.bw_out;
    assign unserviceable_out = ~mon_ok | q_r.block;

endmodule : dpbo_phase_buildout

`default_nettype wire

// file: src/dpbo_params.svh
// Purpose: constants for the phase build-out block
// Assumes: 250 MHz core clock
// Notes: times are kept in their own unit, cycles derived
`ifndef DPBO_PARAMS_SVH
`define DPBO_PARAMS_SVH

`define DPBO_CLK_MHZ 250
`define DPBO_CYC_MIN(ns) ((((ns) * `DPBO_CLK_MHZ) + 999) / 1000)

// register offsets and fields
`define DPBO_ADDR_PBO_CTRL 8'h48
`define DPBO_PBO_EN_BIT 2
`define DPBO_ADDR_AUTO_CTRL 8'h76
`define DPBO_AUTO_BIT 4
`define DPBO_ADDR_BW 8'h69
`define DPBO_ADDR_PHADJ_LO 8'h70
`define DPBO_ADDR_PHADJ_HI 8'h71
`define DPBO_ADDR_TRIM 8'h72
`define DPBO_ADDR_STATUS 8'h7A
`define DPBO_ADDR_UNSERV 8'h7B
`define DPBO_ADDR_FREEZE 8'h7D
`define DPBO_FREEZE_BIT 0

// reset values
`define DPBO_RST_PBO_EN 1'b1
`define DPBO_RST_BW_LOCK 4'h4
`define DPBO_RST_BW_ACQ 4'h7

// bandwidth: ten settings, codes 0..9
`define DPBO_BW_STEPS 10
`define DPBO_BW_MAX 4'h9

// phase units
`define DPBO_PHASE_LSB_PS 101
`define DPBO_TRIM_RANGE_PS 1400
`define DPBO_TRIM_LIMIT (`DPBO_TRIM_RANGE_PS / `DPBO_PHASE_LSB_PS)
`define DPBO_PHADJ_STEP_PS 6
`define DPBO_PHADJ_RANGE_PS 200000
`define DPBO_TRANSIENT_MAX_PS 5000

// timing
`define DPBO_GAP_NS 1000
`define DPBO_LONG_NS 10000
`define DPBO_LEAK_NS 100000
`define DPBO_BAD_NS 40000
`define DPBO_GOOD_NS 400000
`define DPBO_HOLD_NS 2000
`define DPBO_LOL_NS 40000
`define DPBO_REL_NS 400000
`define DPBO_BKT_MAX 4'h3

`endif

// file: src/dpbo_pkg.sv
// Purpose: shared types of the phase build-out block
// Assumes: widths fixed at 16 bit counters
// Notes: constants live in dpbo_params.svh
package dpbo_pkg;

    typedef enum logic [3:0] {
        ST_LOCKED = 4'b0001,
        ST_HOLD = 4'b0010,
        ST_MEAS = 4'b0100,
        ST_INSERT = 4'b1000
    } dpbo_state_e;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [15:0] gap;
        logic [3:0] bkt;
        logic [15:0] leak;
        logic [15:0] bad;
        logic [15:0] good;
        logic ok;
    } dpbo_mon_s;

endpackage : dpbo_pkg

// file: src/dpbo_ref_monitor.sv
// Purpose: activity and quality watch of one reference input
// Assumes: quality_ok_in comes from logic on clock_in
// Notes: reference stays unserviceable until requalified
`timescale 1ns/1ps
`default_nettype none
`include "dpbo_params.svh"

module dpbo_ref_monitor #(
    parameter int GAP_CYC = 250,
    parameter int LONG_CYC = 2500,
    parameter int LEAK_CYC = 25000,
    parameter int BAD_CYC = 10000,
    parameter int GOOD_CYC = 100000
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic ref_pin_in,
    input wire logic quality_ok_in,
    output logic ok_out
);

    dpbo_pkg::dpbo_mon_s q_r;
    dpbo_pkg::dpbo_mon_s q_nxt;
    logic edge_seen;
    logic fault;

    always_comb begin
        q_nxt = q_r;
        q_nxt.sync1 = ref_pin_in;
        q_nxt.sync2 = q_r.sync1;
        q_nxt.prev = q_r.sync2;
        edge_seen = q_r.sync2 & ~q_r.prev;
        // activity: gap since last rising edge
        if (edge_seen) begin
            q_nxt.gap = 16'h0000;
        end else if (q_r.gap != 16'hFFFF) begin
            q_nxt.gap = q_r.gap + 16'h0001;
        end
        // short interruptions fill a leaky bucket, two are tolerated, a third before it leaks rejects
        if (q_r.gap == 16'(GAP_CYC) && !edge_seen && q_r.bkt != 4'hF) begin
            q_nxt.bkt = q_r.bkt + 4'h1;
        end
        if (q_r.leak >= 16'(LEAK_CYC - 1)) begin
            q_nxt.leak = 16'h0000;
            if (q_nxt.bkt != 4'h0) begin
                q_nxt.bkt = q_nxt.bkt - 4'h1;
            end
        end else begin
            q_nxt.leak = q_r.leak + 16'h0001;
        end
        // frequency or purity fault must persist before rejection
        if (quality_ok_in) begin
            q_nxt.bad = 16'h0000;
        end else if (q_r.bad != 16'hFFFF) begin
            q_nxt.bad = q_r.bad + 16'h0001;
        end
        fault = (q_r.gap >= 16'(LONG_CYC)) || (q_r.bkt >= `DPBO_BKT_MAX)
            || (q_r.bad >= 16'(BAD_CYC));
        if (fault) begin
            q_nxt.ok = 1'b0;
            q_nxt.good = 16'h0000;
        end else if (!q_r.ok) begin
            if (q_r.gap >= 16'(GAP_CYC)) begin
                q_nxt.good = 16'h0000;
            end else if (q_r.good >= 16'(GOOD_CYC - 1)) begin
                q_nxt.ok = 1'b1;
            end else begin
                q_nxt.good = q_r.good + 16'h0001;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign ok_out = q_r.ok;

endmodule : dpbo_ref_monitor

`default_nettype wire

// file: test/dpbo_ref_sources.sv
// Purpose: upstream reference clock sources
// Assumes: HALF core cycles per half period
// Notes: a stopped source holds its line low, no edges at all
`timescale 1ns/1ps
`default_nettype none

module dpbo_ref_sources #(
    parameter int HALF = 7
) (
    input wire logic clock_in,
    input wire logic [3:0] run_in,
    output logic [3:0] ref_clk_out
);
    int cnt = 0;
    logic tog = 1'b0;

    always @(posedge clock_in) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) begin
            tog <= ~tog;
        end
    end
    // a lost source goes quiet instead of floating, so activity loss is clean
    assign ref_clk_out = run_in & {4{tog}};
endmodule : dpbo_ref_sources
`default_nettype wire

// file: test/dpbo_phase_buildout_properties.sv
// Purpose: port-level assertions of the phase build-out block
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to the top module, watches its ports only
`timescale 1ns/1ps
`default_nettype none
`include "dpbo_params.svh"

module dpbo_phase_buildout_properties #(
    parameter int NREF = 4,
    parameter int PH_W = 16
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic [NREF-1:0] ref_clk_in,
    input wire logic [NREF-1:0] ref_freq_ok_in,
    input wire logic [NREF-1:0] ref_purity_ok_in,
    input wire logic lock_in,
    input wire logic [PH_W-1:0] phase_meas_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [1:0] sel_ref_out,
    input wire logic sel_valid_out,
    input wire logic holdover_out,
    input wire logic buildout_event_out,
    input wire logic [PH_W-1:0] buildout_offset_out,
    input wire logic [15:0] phase_adjust_out,
    input wire logic [3:0] bandwidth_sel_out,
    input wire logic [NREF-1:0] unserviceable_out
);
    logic [3:0] lk_cl;
    logic [3:0] aq_cl;
    logic bw_wr;
    logic off_wr;

    // codes above nine clamp, so compare against the clamped copy
    always_comb begin
        lk_cl = (reg_wdata_in[3:0] > 4'h9) ? 4'h9 : reg_wdata_in[3:0];
        aq_cl = (reg_wdata_in[7:4] > 4'h9) ? 4'h9 : reg_wdata_in[7:4];
        bw_wr = reg_wr_in && (reg_addr_in == `DPBO_ADDR_BW);
        off_wr = reg_wr_in && (((reg_addr_in == `DPBO_ADDR_PBO_CTRL) && reg_wdata_in[`DPBO_PBO_EN_BIT])
            || ((reg_addr_in == `DPBO_ADDR_AUTO_CTRL) && reg_wdata_in[`DPBO_AUTO_BIT]));
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    AST_EVENT_PULSE: assert property (buildout_event_out |=> !buildout_event_out)
        else $error("build-out event longer than one cycle");
    AST_EVENT_HOLDOVER: assert property (buildout_event_out |-> holdover_out)
        else $error("build-out event without holdover");
    AST_HOLDOVER_ENDS: assert property (buildout_event_out |-> ##[1:700] !holdover_out)
        else $error("holdover did not end after build-out");
    AST_PHADJ_GATED: assert property (off_wr |=> ##1 (phase_adjust_out == 16'h0000))
        else $error("phase adjust applied while build-out on");
    AST_BW_LEGAL: assert property (bandwidth_sel_out <= 4'h9)
        else $error("bandwidth code out of range");
    // code registered one edge earlier follows the lock seen at that edge
    AST_BW_WRITE: assert property (bw_wr ##1 ($stable(lock_in) && !bw_wr) |=>
        (bandwidth_sel_out == ($past(lock_in) ? $past(lk_cl, 2) : $past(aq_cl, 2))))
        else $error("bandwidth code does not follow lock state");
    AST_RESELECT: assert property (sel_valid_out && unserviceable_out[sel_ref_out] |=>
        (!sel_valid_out || (sel_ref_out != $past(sel_ref_out))))
        else $error("failed reference kept selected");
    AST_NO_SEL_HOLDOVER: assert property (!sel_valid_out |-> holdover_out)
        else $error("no reference selected but not in holdover");
    AST_RESET_STATE: assert property ($rose(rstn_in) |->
        (holdover_out && !sel_valid_out && (bandwidth_sel_out == 4'h7) && (&unserviceable_out)))
        else $error("wrong state after reset");
    AST_OFFSET_HELD: assert property ($changed(buildout_offset_out) |->
        ($past(holdover_out) || $past(reg_wr_in) || $past(reg_wr_in, 2)))
        else $error("offset changed outside build-out");
endmodule : dpbo_phase_buildout_properties

bind dpbo_phase_buildout dpbo_phase_buildout_properties #(.NREF(NREF), .PH_W(PH_W)) u_props (
    .clock_in(clock_in), .rstn_in(rstn_in), .ref_clk_in(ref_clk_in), .ref_freq_ok_in(ref_freq_ok_in),
    .ref_purity_ok_in(ref_purity_ok_in), .lock_in(lock_in), .phase_meas_in(phase_meas_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .sel_ref_out(sel_ref_out), .sel_valid_out(sel_valid_out),
    .holdover_out(holdover_out), .buildout_event_out(buildout_event_out),
    .buildout_offset_out(buildout_offset_out), .phase_adjust_out(phase_adjust_out),
    .bandwidth_sel_out(bandwidth_sel_out), .unserviceable_out(unserviceable_out));
`default_nettype wire

// file: test/dpbo_phase_buildout_test.sv
// Purpose: directed test of reference switching and phase build-out
// Assumes: shortened counts through top parameters
// Notes: inputs change on the falling edge only
`timescale 1ns/1ps
`default_nettype none

module dpbo_phase_buildout_test;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [3:0] run = 4'hF;
    logic [3:0] freq_ok = 4'hF;
    logic [3:0] purity = 4'hF;
    logic lock_in = 1'b1;
    logic [15:0] meas = 16'h0064;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] ref_clk, bw, unserv;
    logic [7:0] rdata;
    logic [1:0] sel;
    logic sel_valid, holdover, event_p;
    logic [15:0] offset, phadj;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int ev_cnt = 0;
    int i;

    always #2 clock_in = ~clock_in;

    dpbo_ref_sources u_dpbo_ref_sources (.clock_in(clock_in), .run_in(run), .ref_clk_out(ref_clk));

    dpbo_phase_buildout #(.LEAK_CYC(50), .BAD_CYC(20), .GOOD_CYC(20), .LOL_CYC(20), .REL_CYC(100))
    u_dpbo_phase_buildout (
        .clock_in(clock_in), .rstn_in(rstn_in), .ref_clk_in(ref_clk), .ref_freq_ok_in(freq_ok),
        .ref_purity_ok_in(purity), .lock_in(lock_in), .phase_meas_in(meas), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .sel_ref_out(sel),
        .sel_valid_out(sel_valid), .holdover_out(holdover), .buildout_event_out(event_p),
        .buildout_offset_out(offset), .phase_adjust_out(phadj), .bandwidth_sel_out(bw),
        .unserviceable_out(unserv));

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // extra cycle after the strobe so registered outputs have settled
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_in);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clock_in);
        wr = 1'b0;
        @(negedge clock_in);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock_in);
        addr = a;
        rd = 1'b1;
        @(negedge clock_in);
        rd = 1'b0;
        @(negedge clock_in);
        chk(16'(rdata), 16'(exp));
    endtask : rd_chk

    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (event_p === 1'b1) begin
            ev_cnt <= ev_cnt + 1;
        end
        if (cyc == 10000) begin
            err_total++;
            report_and_stop();
        end
    end

    initial begin
        repeat (10) @(negedge clock_in);
        chk(16'(bw), 16'h0007);
        chk(16'(unserv), 16'h000F);
        rstn_in = 1'b1;
        rd_chk(8'h48, 8'h04);
        rd_chk(8'h69, 8'h74);
        rd_chk(8'h3C, 8'h00);
        for (i = 0; i < 300 && sel_valid !== 1'b1; i++) @(negedge clock_in);
        chk(16'(sel), 16'h0000);
        chk(16'(sel_valid), 16'h0001);
        chk(16'(holdover), 16'h0000);
        chk(16'(ev_cnt), 16'h0000);
        chk(16'(bw), 16'h0004);
        wr_reg(8'h69, 8'hC2);
        chk(16'(bw), 16'h0002);
        lock_in = 1'b0;
        repeat (2) @(negedge clock_in);
        chk(16'(bw), 16'h0009);
        lock_in = 1'b1;
        // one short gap on a standby source must be tolerated
        run[2] = 1'b0;
        repeat (300) @(negedge clock_in);
        run[2] = 1'b1;
        // trim beyond the limit, so the clamp shows in the offset
        wr_reg(8'h72, 8'hF0);
        freq_ok[0] = 1'b0;
        for (i = 0; i < 100 && ev_cnt == 0; i++) @(negedge clock_in);
        chk(16'(sel), 16'h0001);
        chk(16'(holdover), 16'h0001);
        chk(16'(unserv[0]), 16'h0001);
        for (i = 0; i < 800 && holdover !== 1'b0; i++) @(negedge clock_in);
        chk(offset, 16'h0057);
        wr_reg(8'h7D, 8'h01);
        run[1] = 1'b0;
        purity[3] = 1'b0;
        for (i = 0; i < 3000 && sel !== 2'h2; i++) @(negedge clock_in);
        chk(16'(sel), 16'h0002);
        chk(16'(ev_cnt), 16'h0001);
        chk(offset, 16'h0057);
        rd_chk(8'h7B, 8'h0B);
        wr_reg(8'h70, 8'h34);
        wr_reg(8'h71, 8'h12);
        chk(phadj, 16'h0000);
        wr_reg(8'h48, 8'h00);
        chk(offset, 16'h0000);
        chk(phadj, 16'h1234);
        wr_reg(8'h76, 8'h10);
        chk(phadj, 16'h0000);
        wr_reg(8'h76, 8'h00);
        wr_reg(8'h7A, 8'hFF);
        rd_chk(8'h7A, 8'h1D);
        wr_reg(8'h7D, 8'h00);
        meas = 16'hFFF6;
        wr_reg(8'h48, 8'h04);
        chk(16'(ev_cnt), 16'h0002);
        for (i = 0; i < 800 && holdover !== 1'b0; i++) @(negedge clock_in);
        chk(offset, 16'hFFE9);
        chk(phadj, 16'h0000);
        // lock lost long enough blocks the selected source, later released
        purity[3] = 1'b1;
        repeat (30) @(negedge clock_in);
        lock_in = 1'b0;
        for (i = 0; i < 100 && sel !== 2'h3; i++) @(negedge clock_in);
        lock_in = 1'b1;
        chk(16'(sel), 16'h0003);
        chk(16'(unserv), 16'h0007);
        for (i = 0; i < 800 && holdover !== 1'b0; i++) @(negedge clock_in);
        chk(16'(ev_cnt), 16'h0003);
        chk(16'(unserv), 16'h0003);
        report_and_stop();
    end
endmodule : dpbo_phase_buildout_test
`default_nettype wire
